// ### verilog/cpr_defs.svh
// Offsets, field positions, reset values and timing counts of the clock,
// power and reset control block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef CPR_DEFS_SVH
`define CPR_DEFS_SVH
`define CPR_OFF_PWR      5'h00
`define CPR_OFF_STATUS   5'h04
`define CPR_OFF_PORTS    5'h08
`define CPR_OFF_STACK    5'h0c
`define CPR_OFF_SERBUF   5'h10
`define CPR_OFF_GENERAL  5'h14
`define CPR_BIT_IDLE     0
`define CPR_BIT_PDOWN    1
`define CPR_BIT_COLD     4
`define CPR_PWR_MASK     8'h1f
`define CPR_PWR_KEEP     8'h10
`define CPR_RST_PORTS    32'hffffffff
`define CPR_RST_STACK    8'h07
`define CPR_RST_GENERAL  8'h00
`define CPR_CLK_DIV      2
`define CPR_STATES       3'h6
`define CPR_SAMPLE_STATE 3'h4
`define CPR_HOLD_CYCLES  2'h2
`endif

// ### verilog/cpr_pkg.sv
// Types shared by the clock, power and reset control block.
// Assumes cpr_defs.svh is on the include path.
`include "cpr_defs.svh"
package cpr_pkg;
    typedef enum logic [2:0] {
        MODE_RUN,
        MODE_IDLE,
        MODE_PDOWN,
        MODE_WAKE,
        MODE_RESET
    } mode_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } avmReq_t;

    typedef struct packed {
        logic        oscRun;
        logic        cpuClkEn;
        logic        periphClkEn;
        logic        coreRst;
        logic [31:0] portLatch;
        logic [7:0]  stackPtr;
    } cprOut_t;
endpackage

// ### verilog/clock_power_reset_control.sv
// Clock division, idle and power-down control, and reset filtering.
// Assumes mclk is the oscillator, irqPending comes from same-clock logic,
// and rstPin arrives asynchronously from the board.
// Low ce freezes every flop; sys_rst is the power-on reset.
//
// What this block does
// - Halve oscillator; clock enables and reset sampling step on divided tick only.
// - Idle bit set stops processor clock.
// - Idle keeps peripheral and interrupt clocks running.
// - Enabled interrupt or reset ends idle.
// - Power-down bit stops all clocks, oscillator too.
// - Power-down ignores interrupts; only reset exits.
// - Reset pin sampled once per cycle, S5P2.
// - Glitch filter keeps short pulses from resetting.
// - Reset sets port latches ones, stack seven.
// - Reset clears power control except cold flag.
// - Reset clears other registers, serial buffer kept.
// - Power-on sets cold flag; software may clear.
`timescale 1ns/1ps
`include "cpr_defs.svh"
module clock_power_reset_control (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    input  wire logic             rstPin,
    input  wire logic             irqPending,
    input  wire cpr_pkg::avmReq_t avs,
    output logic [31:0]           avsReadData,
    output logic                  avsWaitRequest,
    output cpr_pkg::cprOut_t      ctl
);

    // Every flip-flop of the block lives in this one record.
    // Keeping it in one place makes the clock enable and the power-on
    // reset act on all of it alike, so no stray flop can run on while
    // the rest of the block is frozen.
    typedef struct packed {
        logic            sync1;
        logic            sync2;
        logic [2:0]      filt;
        logic            filtLvl;
        logic            phase;
        logic [2:0]      stateIdx;
        logic [1:0]      holdCnt;
        logic            inReset;
        cpr_pkg::mode_t  mode;
        logic            oscRun;
        logic [7:0]      pwr;
        logic [31:0]     ports;
        logic [7:0]      stack;
        logic [7:0]      general;
        logic [7:0]      serBuf;
        logic [31:0]     rdata;
        logic            ack;
        logic            cpuEn;
        logic            perEn;
    } state_t;

    state_t st_q;
    state_t st_d;

    logic        divTick;
    logic        sampleNow;
    logic        busReq;
    logic        doWrite;
    logic [31:0] beMask;
    logic [31:0] wval;
    logic [31:0] statusWord;

    // The divided clock is one tick per two oscillator periods.
    // Every flop steps on the rising oscillator edge alone, so a lopsided duty
    // cycle on the oscillator cannot shorten any internal step.
    // While the oscillator is stopped the tick stays low, which is what
    // silences both clock enables in power-down.
    assign divTick   = st_q.oscRun & st_q.phase;
    // Phase two of state five is the only reset sampling point.
    assign sampleNow = divTick & (st_q.stateIdx == `CPR_SAMPLE_STATE);

    // Bus handshake: one wait cycle, then the answer.
    // The wait cycle gives the read mux a full period to settle into the
    // data register; a back-to-back request pays the wait again because
    // the ack drops for one cycle after every answer.
    assign busReq         = avs.read | avs.write;
    assign avsWaitRequest = busReq & ~st_q.ack;
    assign doWrite        = avs.write & st_q.ack;
    assign avsReadData    = st_q.rdata;

    // Byte enables select which lanes of the write data land.
    always_comb begin
        beMask = {{8{avs.byteenable[3]}}, {8{avs.byteenable[2]}},
                  {8{avs.byteenable[1]}}, {8{avs.byteenable[0]}}};
    end

    // Live state seen by software.
    // It is read-only and lets software and tests follow the mode machine
    // and the reset filter.
    always_comb begin
        statusWord        = 32'h00000000;
        statusWord[2:0]   = st_q.mode;
        statusWord[3]     = st_q.inReset;
        statusWord[6:4]   = st_q.stateIdx;
        statusWord[7]     = st_q.phase;
        statusWord[8]     = st_q.oscRun;
        statusWord[9]     = st_q.filtLvl;
        statusWord[11:10] = st_q.holdCnt;
    end

    // Next state of the whole block.
    always_comb begin
        st_d = st_q;
        wval = 32'h00000000;

        // Two-stage synchroniser, then a three-sample majority vote.
        // Only the second stage feeds logic; the first may go metastable.
        // The vote needs two of three samples high, so a pulse of one
        // oscillator period never reaches the filtered level.
        st_d.sync1 = rstPin;
        st_d.sync2 = st_q.sync1;
        st_d.filt  = {st_q.filt[1:0], st_q.sync2};
        st_d.filtLvl = (st_q.filt[0] & st_q.filt[1]) |
                       (st_q.filt[1] & st_q.filt[2]) |
                       (st_q.filt[0] & st_q.filt[2]);

        // Oscillator period counter: two phases per state, six states.
        // Twelve oscillator periods make one machine cycle; the counter
        // freezes with the oscillator, so a wake-up resumes mid-cycle.
        if (st_q.oscRun) begin
            st_d.phase = ~st_q.phase;
            if (st_q.phase) begin
                if (st_q.stateIdx == `CPR_STATES - 3'h1) begin
                    st_d.stateIdx = 3'h0;
                end else begin
                    st_d.stateIdx = st_q.stateIdx + 3'h1;
                end
            end
        end

        // Reset takes effect after two consecutive high samples.
        // A single low sample clears the count, so the pin must stay high
        // across two sampling points; one sample alone is not enough.
        // Reset is released at the first low sample.
        if (sampleNow) begin
            if (st_q.filtLvl) begin
                if (st_q.holdCnt != `CPR_HOLD_CYCLES) begin
                    st_d.holdCnt = st_q.holdCnt + 2'h1;
                end
                if (st_q.holdCnt >= `CPR_HOLD_CYCLES - 2'h1) begin
                    st_d.inReset = 1'b1;
                end
            end else begin
                st_d.holdCnt = 2'h0;
                st_d.inReset = 1'b0;
            end
        end

        // Mode sequencing; power-down has priority over idle.
        // Reset is checked first in every mode but power-down, which waits on the filtered pin level.
        // Power-down leaves only through the wake state, which restarts
        // the oscillator and then demands the full hold count again.
        // A pin that drops before the hold count completes sends the
        // block back to power-down with the oscillator stopped, so a
        // short pulse cannot leave the device running without a reset.
        case (st_q.mode)
            cpr_pkg::MODE_RUN: begin
                if (st_q.inReset) begin
                    st_d.mode = cpr_pkg::MODE_RESET;
                end else if (st_q.pwr[`CPR_BIT_PDOWN]) begin
                    st_d.mode   = cpr_pkg::MODE_PDOWN;
                    st_d.oscRun = 1'b0;
                end else if (st_q.pwr[`CPR_BIT_IDLE]) begin
                    st_d.mode = cpr_pkg::MODE_IDLE;
                end
            end
            cpr_pkg::MODE_IDLE: begin
                if (st_q.inReset) begin
                    st_d.mode = cpr_pkg::MODE_RESET;
                end else if (irqPending) begin
                    st_d.mode = cpr_pkg::MODE_RUN;
                    st_d.pwr[`CPR_BIT_IDLE] = 1'b0;
                end
            end
            cpr_pkg::MODE_PDOWN: begin
                // Interrupts are not looked at here.
                if (st_q.filtLvl) begin
                    st_d.mode   = cpr_pkg::MODE_WAKE;
                    st_d.oscRun = 1'b1;
                end
            end
            cpr_pkg::MODE_WAKE: begin
                // Oscillator restarted; the pin must survive the hold count.
                if (st_q.inReset) begin
                    st_d.mode = cpr_pkg::MODE_RESET;
                end else if (sampleNow & ~st_q.filtLvl) begin
                    st_d.mode   = cpr_pkg::MODE_PDOWN;
                    st_d.oscRun = 1'b0;
                    st_d.phase  = 1'b0;
                end
            end
            cpr_pkg::MODE_RESET: begin
                if (!st_q.inReset) begin
                    st_d.mode = cpr_pkg::MODE_RUN;
                end
            end
            default: begin
                st_d.mode = cpr_pkg::MODE_RESET;
            end
        endcase

        // Register writes, ignored while reset is held.
        // Writes are still acknowledged then, so a master never hangs.
        // Unmapped offsets are acknowledged and dropped.
        if (doWrite && !st_q.inReset) begin
            case (avs.address)
                `CPR_OFF_PWR: begin
                    wval = ({24'h000000, st_q.pwr} & ~beMask) |
                           (avs.writedata & beMask);
                    st_d.pwr = wval[7:0] & `CPR_PWR_MASK;
                end
                `CPR_OFF_PORTS: begin
                    st_d.ports = (st_q.ports & ~beMask) | (avs.writedata & beMask);
                end
                `CPR_OFF_STACK: begin
                    if (avs.byteenable[0]) begin
                        st_d.stack = avs.writedata[7:0];
                    end
                end
                `CPR_OFF_SERBUF: begin
                    if (avs.byteenable[0]) begin
                        st_d.serBuf = avs.writedata[7:0];
                    end
                end
                `CPR_OFF_GENERAL: begin
                    if (avs.byteenable[0]) begin
                        st_d.general = avs.writedata[7:0];
                    end
                end
                default: begin
                    wval = 32'h00000000;
                end
            endcase
        end

        // Reset values are forced for as long as reset is held.
        // The serial buffer keeps its contents across a core reset; only
        // the power-on reset clears it.
        if (st_q.inReset) begin
            st_d.ports   = `CPR_RST_PORTS;
            st_d.stack   = `CPR_RST_STACK;
            st_d.pwr     = st_q.pwr & `CPR_PWR_KEEP;
            st_d.general = `CPR_RST_GENERAL;
            st_d.serBuf  = st_q.serBuf;
        end

        // Read data is captured in the wait cycle and shown with the ack.
        // The register holds the data until the next read is captured.
        st_d.ack = busReq & ~st_q.ack;
        if (avs.read && !st_q.ack) begin
            case (avs.address)
                `CPR_OFF_PWR:     st_d.rdata = {24'h000000, st_q.pwr};
                `CPR_OFF_STATUS:  st_d.rdata = statusWord;
                `CPR_OFF_PORTS:   st_d.rdata = st_q.ports;
                `CPR_OFF_STACK:   st_d.rdata = {24'h000000, st_q.stack};
                `CPR_OFF_SERBUF:  st_d.rdata = {24'h000000, st_q.serBuf};
                `CPR_OFF_GENERAL: st_d.rdata = {24'h000000, st_q.general};
                default:          st_d.rdata = 32'h00000000;
            endcase
        end

        // Clock enables are one-tick strobes of the divided clock.
        // Idle drops only the processor strobe; peripherals and interrupt
        // logic keep theirs.
        st_d.cpuEn = divTick & (st_q.mode == cpr_pkg::MODE_RUN);
        st_d.perEn = divTick & ((st_q.mode == cpr_pkg::MODE_RUN) |
                                (st_q.mode == cpr_pkg::MODE_IDLE));
    end

    // Single state register; power-on sets the cold-start flag.
    // Low clock enable freezes every flop, the bus ack included.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q          <= '0;
            st_q.mode     <= cpr_pkg::MODE_RUN;
            st_q.oscRun   <= 1'b1;
            st_q.pwr      <= `CPR_PWR_KEEP;
            st_q.ports    <= `CPR_RST_PORTS;
            st_q.stack    <= `CPR_RST_STACK;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state record.
    // One assignment drives the whole output record, so every member
    // has a single driver and comes from a flip-flop.
    assign ctl = '{
        oscRun:      st_q.oscRun,
        cpuClkEn:    st_q.cpuEn,
        periphClkEn: st_q.perEn,
        coreRst:     st_q.inReset,
        portLatch:   st_q.ports,
        stackPtr:    st_q.stack
    };

endmodule

// ### tb/cpr_properties.sv
// Concurrent checks on the ports of clock_power_reset_control.
// Assumes one clock domain, mclk, and that ce stays high while checking.
`timescale 1ns/1ps
module cpr_properties (
    input logic             mclk,
    input logic             sys_rst,
    input logic             ce,
    input logic             rstPin,
    input logic             irqPending,
    input cpr_pkg::avmReq_t avs,
    input logic [31:0]      avsReadData,
    input logic             avsWaitRequest,
    input cpr_pkg::cprOut_t ctl
);
    logic [4:0] pinHigh_q;

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Counts the cycles the reset pin has stayed high, saturating.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pinHigh_q <= 5'h00;
        end else if (!rstPin) begin
            pinHigh_q <= 5'h00;
        end else if (pinHigh_q != 5'h1f) begin
            pinHigh_q <= pinHigh_q + 5'h01;
        end
    end

    // Clock enables, power modes, reset filtering and bus handshake.
    cpu_pulse_a: assert property (ctl.cpuClkEn |=> !ctl.cpuClkEn)
        else $error("cpu enable held two cycles");
    per_pulse_a: assert property (ctl.periphClkEn |=> !ctl.periphClkEn)
        else $error("peripheral enable held two cycles");
    cpu_with_per_a: assert property (ctl.cpuClkEn |-> ctl.periphClkEn)
        else $error("cpu enable without peripheral enable");
    irq_wakes_a: assert property ((ctl.periphClkEn || $past(ctl.periphClkEn)) &&
        !ctl.cpuClkEn && irqPending && ctl.oscRun && !ctl.coreRst |-> ##[1:4] ctl.cpuClkEn)
        else $error("interrupt did not restart the cpu clock");
    pdown_quiet_a: assert property (!ctl.oscRun |=> !ctl.cpuClkEn && !ctl.periphClkEn)
        else $error("clock enable while oscillator stopped");
    pdown_irq_a: assert property ((!rstPin)[*8] ##0 (!ctl.oscRun && irqPending)
        |=> !ctl.oscRun)
        else $error("interrupt left power-down");
    glitch_filter_a: assert property ($rose(ctl.coreRst) |-> pinHigh_q >= 5'h0c)
        else $error("core reset after a short pin pulse");
    reset_values_a: assert property (ctl.coreRst && $past(ctl.coreRst) |->
        ctl.stackPtr == 8'h07 && ctl.portLatch == 32'hffffffff)
        else $error("wrong port or stack value in reset");
    bus_ack_a: assert property ($rose(avs.read || avs.write) |->
        avsWaitRequest ##1 !avsWaitRequest)
        else $error("bus answer not one cycle after request");
endmodule

bind clock_power_reset_control cpr_properties cpr_properties_i (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .rstPin(rstPin), .irqPending(irqPending),
    .avs(avs), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .ctl(ctl));

// ### tb/reset_source_model.sv
// Board reset source and interrupt source facing the block.
// Assumes its tasks are called just after a rising edge of mclk.
`timescale 1ns/1ps
module reset_source_model (
    input  wire logic mclk,
    output logic      rstPin,
    output logic      irqPending
);
    // The pin has a pull-down, so it rests low between presses.
    initial begin
        rstPin     = 1'b0;
        irqPending = 1'b0;
    end

    // Holds the reset pin high for n oscillator cycles.
    task automatic press(input int n);
        rstPin <= 1'b1;
        repeat (n) @(posedge mclk);
        rstPin <= 1'b0;
    endtask

    // Raises the enabled interrupt for n cycles.
    task automatic irq(input int n);
        irqPending <= 1'b1;
        repeat (n) @(posedge mclk);
        irqPending <= 1'b0;
    endtask
endmodule

// ### tb/clock_power_reset_control_tb.sv
// Self-checking bench for the clock, power and reset control block.
// Assumes the checker is bound and reset_source_model drives pin and interrupt.
`timescale 1ns/1ps
module clock_power_reset_control_tb;
    logic             mclk;
    logic             sys_rst = 1'b1;
    logic             ce = 1'b1;
    logic             rstPin;
    logic             irqPending;
    cpr_pkg::avmReq_t avs = '{byteenable: 4'hf, default: '0};
    logic [31:0]      avsReadData;
    logic             avsWaitRequest;
    cpr_pkg::cprOut_t ctl;
    int               fails = 0;
    int               checks = 0;
    int               cyc = 0;
    int               cpuN;
    int               perN;
    logic [31:0]      rd;
    logic             sawRst = 1'b0;
    logic [31:0]      pw [2] = '{32'h1c, 32'h0c};
    int               gl [3] = '{1, 3, 6};

    clock_power_reset_control clock_power_reset_control_i (
        .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .rstPin(rstPin), .irqPending(irqPending),
        .avs(avs), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .ctl(ctl));
    reset_source_model reset_source_model_i (
        .mclk(mclk), .rstPin(rstPin), .irqPending(irqPending));

    // Compares one value and counts the comparison.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One bus transfer, held until waitrequest is sampled low.
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs.read      <= !w;
        avs.write     <= w;
        avs.address   <= a;
        avs.writedata <= d;
        do begin
            @(posedge mclk);
        end while (avsWaitRequest !== 1'b0);
        rd = avsReadData;
        avs.read  <= 1'b0;
        avs.write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // Counts clock enable pulses over n cycles.
    task automatic cnt(input int n);
        cpuN = 0;
        perN = 0;
        repeat (n) begin
            @(posedge mclk);
            cpuN += (ctl.cpuClkEn === 1'b1);
            perN += (ctl.periphClkEn === 1'b1);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Remembers any core reset and cuts a hung run short.
    always @(posedge mclk) begin
        if (ctl.coreRst === 1'b1) sawRst <= 1'b1;
        cyc++;
        if (cyc == 3000) begin
            fails++;
            end_sim();
        end
    end

    // Main sequence: reset values, clocking, filtering, reset loads, idle, power-down.
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rdchk(5'h00, 32'h10);
        rdchk(5'h14, 32'h0);
        rdchk(5'h18, 32'h0);
        chk(32'(ctl.stackPtr), 32'h07);
        chk(ctl.portLatch, 32'hffffffff);
        cnt(20);
        chk(cpuN, 10);
        foreach (gl[i]) begin
            reset_source_model_i.press(gl[i]);
            repeat (30) @(posedge mclk);
        end
        chk(32'(sawRst), 32'h0);
        acc(1'b1, 5'h10, 32'ha5);
        for (int i = 0; i < 2; i++) begin
            acc(1'b1, 5'h0c, 32'h55);
            acc(1'b1, 5'h14, 32'h3c);
            acc(1'b1, 5'h08, 32'h12345678);
            acc(1'b1, 5'h00, pw[i]);
            chk(32'(ctl.stackPtr), 32'h55);
            rdchk(5'h00, pw[i]);
            reset_source_model_i.press(40);
            chk(32'(ctl.coreRst), 32'h1);
            acc(1'b1, 5'h0c, 32'h99);
            chk(32'(ctl.stackPtr), 32'h07);
            chk(ctl.portLatch, 32'hffffffff);
            repeat (30) @(posedge mclk);
            rdchk(5'h00, pw[i] & 32'h10);
            rdchk(5'h14, 32'h0);
            rdchk(5'h10, 32'ha5);
        end
        acc(1'b1, 5'h00, 32'h01);
        acc(1'b0, 5'h04, 32'h0);
        chk(rd & 32'h7, 32'h1);
        cnt(20);
        chk(cpuN, 0);
        chk(perN, 10);
        reset_source_model_i.irq(2);
        cnt(20);
        chk(cpuN, 10);
        rdchk(5'h00, 32'h0);
        acc(1'b1, 5'h00, 32'h02);
        repeat (3) @(posedge mclk);
        chk(32'(ctl.oscRun), 32'h0);
        cnt(20);
        chk(perN, 0);
        reset_source_model_i.irq(10);
        chk(32'(ctl.oscRun), 32'h0);
        reset_source_model_i.press(60);
        repeat (30) @(posedge mclk);
        chk(32'(ctl.oscRun), 32'h1);
        rdchk(5'h00, 32'h0);
        cnt(20);
        chk(cpuN, 10);
        end_sim();
    end
endmodule
